// ---- core/dpbr_pkg.sv ----
// package for the dock power, boot and reset control block
// assumes a single 20 MHz core clock and synchronous pin-level inputs
package dpbr_pkg;
    localparam int CLK_HZ = 20_000_000;
    // low-speed usb bit rate in bits per second
    localparam int LS_BIT_RATE = 1_500_000;
    // bit enable divisor, rounded down so the enable never runs slow
    localparam int LS_DIV = CLK_HZ / LS_BIT_RATE;
    localparam logic [3:0] LS_DIV_LAST = 4'(LS_DIV - 1);
    // boot settling time after power good, in ns, and its cycle count
    localparam int BOOT_SETTLE_NS = 1000;
    localparam int BOOT_SETTLE_CYC = (BOOT_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] BOOT_SETTLE_LAST = 8'(BOOT_SETTLE_CYC - 1);
    // reset values
    localparam logic RST_SYS_RESET_N = 1'b0;
    localparam logic RST_ADP_SWITCH = 1'b0;
    localparam logic RST_USB_SEL = 1'b0;

    typedef enum logic [4:0] {
        BOOT_OFF = 5'b0_0001,
        BOOT_SETTLE = 5'b0_0010,
        BOOT_SAMPLE = 5'b0_0100,
        BOOT_APP = 5'b0_1000,
        BOOT_EXT = 5'b1_0000
    } dpbr_boot_t;

    typedef enum logic {
        USB_ROUTE_UPSTREAM = 1'b0,
        USB_ROUTE_DEBUG = 1'b1
    } dpbr_route_t;
endpackage : dpbr_pkg

// ---- core/dpbr_usb_if.sv ----
// carrier between the top and the usb routing module
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface dpbr_usb_if;
    logic sel_debug;
    logic tx_active;
    logic bit_en;
    modport ctrl (output sel_debug, output tx_active, input bit_en);
    modport mux (input sel_debug, input tx_active, output bit_en);
endinterface : dpbr_usb_if

// ---- core/dpbr_usb_route.sv ----
// usb low-speed endpoint routing and d- pull-up control
// assumes tx_active comes from the endpoint transceiver on core_clk
`timescale 1ns/1ps
module dpbr_usb_route
    import dpbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    dpbr_usb_if.mux usb,
    output logic up_pullup_en,
    output logic dbg_pullup_en,
    output logic up_route_en,
    output logic dbg_route_en
);
    logic [3:0] div_q;
    logic [3:0] div_d;
    logic div_wrap;

    // divider gives the 1.5 Mbps bit enable; link never runs slower
    assign div_wrap = (div_q == LS_DIV_LAST);
    assign div_d = div_wrap ? 4'h0 : div_q + 4'h1;
    assign usb.bit_en = div_wrap;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 4'h0;
            up_pullup_en <= 1'b0;
            dbg_pullup_en <= 1'b0;
            up_route_en <= 1'b0;
            dbg_route_en <= 1'b0;
        end else begin
            div_q <= div_d;
            up_route_en <= !usb.sel_debug;
            dbg_route_en <= usb.sel_debug;
            // pull-up only while receiving, on the selected port
            up_pullup_en <= !usb.tx_active && !usb.sel_debug;
            dbg_pullup_en <= !usb.tx_active && usb.sel_debug;
        end
    end
endmodule : dpbr_usb_route

// ---- core/dpbr_top.sv ----
// dock power-source selection, boot path decision and reset supervision
// assumes supply-good and comparator levels arrive synchronous to core_clk
`timescale 1ns/1ps
module dpbr_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic main_3v3_input_good,
    input wire logic adapter_input_good,
    input wire logic main_3v3_below_2v85,
    input wire logic internal_3v3_rail_good,
    input wire logic adapter_path_cfg_pin_ext,
    input wire logic switched_out_enable_cfg,
    input wire logic switched_3v3_output_uv,
    input wire logic manual_reset_in,
    input wire logic manual_reset_active_low,
    input wire logic upstream_pd_attached,
    input wire logic fw_force_debug,
    input wire logic usb_tx_active,
    output logic adapter_switch_close,
    output logic use_main_supply,
    output logic boot_run,
    output logic app_load_req,
    output logic core_enable,
    output logic switched_3v3_output_en,
    output logic output_pulldown_en,
    output logic system_reset_out_n,
    output logic usb_bit_en,
    output logic upstream_dminus_pullup,
    output logic debug_dminus_pullup,
    output logic upstream_route_en,
    output logic debug_route_en
);
    import dpbr_pkg::*;

    dpbr_boot_t boot_q;
    dpbr_boot_t boot_d;
    logic [7:0] settle_q;
    logic [7:0] settle_d;
    logic ext_path_q;
    logic ext_path_d;
    logic main_q;
    logic hard_reset;
    logic supply_good;
    logic manual_reset_in_asserted;
    logic reset_cond;
    logic boot_done;
    logic settle_done;
    logic route_debug;
    logic boot_restart;
    logic ext_path_pick;
    logic in_sample;
    logic in_app;
    logic in_ext;
    logic adapter_switch_close_d;
    logic use_main_supply_d;
    logic boot_run_d;
    logic app_load_req_d;
    logic core_enable_d;
    logic out_switch_on;
    logic system_reset_out_n_d;

    dpbr_usb_if usb ();

    assign supply_good = internal_3v3_rail_good && (main_3v3_input_good || adapter_input_good);
    // losing main while adapter also present forces a hard reset
    assign hard_reset = main_q && adapter_input_good && main_3v3_below_2v85;
    assign manual_reset_in_asserted = manual_reset_in ^ manual_reset_active_low;
    assign reset_cond = switched_3v3_output_uv || manual_reset_in_asserted;
    assign settle_done = (settle_q == BOOT_SETTLE_LAST);
    assign in_sample = (boot_q == BOOT_SAMPLE);
    assign in_app = (boot_q == BOOT_APP);
    assign in_ext = (boot_q == BOOT_EXT);
    assign boot_done = in_app || in_ext;
    // any supply drop or main loss restarts the whole boot sequence
    assign boot_restart = !supply_good || hard_reset;
    // only adapter-only power-up may close the adapter path
    assign ext_path_pick = adapter_path_cfg_pin_ext && !main_3v3_input_good;
    assign route_debug = fw_force_debug || !upstream_pd_attached;
    assign usb.sel_debug = route_debug;
    assign usb.tx_active = usb_tx_active;

    always_comb begin
        boot_d = boot_q;
        settle_d = settle_q;
        ext_path_d = ext_path_q;
        if (boot_restart) begin
            boot_d = BOOT_OFF;
            settle_d = 8'h00;
        end else begin
            unique case (boot_q)
                BOOT_OFF: begin
                    boot_d = BOOT_SETTLE;
                end
                BOOT_SETTLE: begin
                    settle_d = settle_q + 8'h01;
                    if (settle_done) begin
                        boot_d = BOOT_SAMPLE;
                    end
                end
                BOOT_SAMPLE: begin
                    ext_path_d = ext_path_pick;
                    boot_d = ext_path_pick ? BOOT_EXT : BOOT_APP;
                end
                BOOT_APP: begin
                    boot_d = BOOT_APP;
                end
                BOOT_EXT: begin
                    boot_d = BOOT_EXT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_q <= BOOT_OFF;
            settle_q <= 8'h00;
        end else begin
            boot_q <= boot_d;
            settle_q <= settle_d;
        end
    end

    // decision register; only the sample state changes it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_path_q <= 1'b0;
        end else begin
            ext_path_q <= ext_path_d;
        end
    end

    // previous main presence, to see main lost while the adapter holds up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_q <= 1'b0;
        end else begin
            main_q <= main_3v3_input_good;
        end
    end

    assign adapter_switch_close_d = in_ext && ext_path_q;
    // main wins whenever present; switching over to main never resets the core, losing it does
    assign use_main_supply_d = main_3v3_input_good;
    assign boot_run_d = in_sample || boot_done;
    assign app_load_req_d = in_app;
    assign core_enable_d = supply_good && !hard_reset;
    // the output switch waits for a final boot decision and the main input
    assign out_switch_on = switched_out_enable_cfg && main_3v3_input_good && boot_done;
    assign system_reset_out_n_d = !reset_cond;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            adapter_switch_close <= RST_ADP_SWITCH;
            use_main_supply <= 1'b0;
        end else begin
            adapter_switch_close <= adapter_switch_close_d;
            use_main_supply <= use_main_supply_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_run <= 1'b0;
            app_load_req <= 1'b0;
            core_enable <= 1'b0;
        end else begin
            boot_run <= boot_run_d;
            app_load_req <= app_load_req_d;
            core_enable <= core_enable_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            switched_3v3_output_en <= 1'b0;
            output_pulldown_en <= 1'b1;
        end else begin
            switched_3v3_output_en <= out_switch_on;
            output_pulldown_en <= !out_switch_on;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            system_reset_out_n <= RST_SYS_RESET_N;
        end else begin
            system_reset_out_n <= system_reset_out_n_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            usb_bit_en <= 1'b0;
        end else begin
            usb_bit_en <= usb.bit_en;
        end
    end

    dpbr_usb_route u_route (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .usb(usb),
        .up_pullup_en(upstream_dminus_pullup),
        .dbg_pullup_en(debug_dminus_pullup),
        .up_route_en(upstream_route_en),
        .dbg_route_en(debug_route_en)
    );
endmodule : dpbr_top

// ---- sim/dpbr_properties.sv ----
// checker for reset, output switch, pull-up, routing and boot outputs
// assumes it is bound to dpbr_top and runs on core_clk
`timescale 1ns/1ps
module dpbr_properties (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic switched_3v3_output_uv,
    input wire logic manual_reset_in,
    input wire logic manual_reset_active_low,
    input wire logic fw_force_debug,
    input wire logic usb_tx_active,
    input wire logic adapter_switch_close,
    input wire logic app_load_req,
    input wire logic switched_3v3_output_en,
    input wire logic output_pulldown_en,
    input wire logic system_reset_out_n,
    input wire logic usb_bit_en,
    input wire logic upstream_dminus_pullup,
    input wire logic debug_dminus_pullup,
    input wire logic upstream_route_en,
    input wire logic debug_route_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_gap; (!usb_bit_en) [*8]; endsequence
    property p_uv; switched_3v3_output_uv |=> !system_reset_out_n; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage left reset high");
    property p_man; manual_reset_in != manual_reset_active_low |=> !system_reset_out_n; endproperty
    a_man: assert property (p_man) else $error("manual reset ignored");
    property p_pd; output_pulldown_en != switched_3v3_output_en; endproperty
    a_pd: assert property (p_pd) else $error("pulldown not inverse of enable");
    property p_tx; usb_tx_active |=> !upstream_dminus_pullup && !debug_dminus_pullup; endproperty
    a_tx: assert property (p_tx) else $error("pull-up on while sending");
    property p_rx; !usb_tx_active && fw_force_debug |=> debug_dminus_pullup; endproperty
    a_rx: assert property (p_rx) else $error("pull-up missing on debug port");
    property p_rt; fw_force_debug |=> debug_route_en && !upstream_route_en; endproperty
    a_rt: assert property (p_rt) else $error("endpoint not on debug port");
    property p_bit; usb_bit_en |=> s_gap; endproperty
    a_bit: assert property (p_bit) else $error("bit enable too close");
    property p_boot; $rose(adapter_switch_close) |-> !app_load_req; endproperty
    a_boot: assert property (p_boot) else $error("switch closed on app path");
endmodule : dpbr_properties
bind dpbr_top dpbr_properties u_props (.core_clk, .rst_b, .switched_3v3_output_uv,
    .manual_reset_in, .manual_reset_active_low, .fw_force_debug, .usb_tx_active,
    .adapter_switch_close, .app_load_req, .switched_3v3_output_en, .output_pulldown_en,
    .system_reset_out_n, .usb_bit_en, .upstream_dminus_pullup, .debug_dminus_pullup,
    .upstream_route_en, .debug_route_en);

// ---- sim/dpbr_supply_model.sv ----
// supplies and switched output seen by the controller
// assumes the bench sets supply presence through main_on and adp_on
`timescale 1ns/1ps
module dpbr_supply_model (
    input wire logic core_clk,
    input wire logic main_on,
    input wire logic adp_on,
    input wire logic switched_3v3_output_en,
    output logic main_3v3_input_good,
    output logic adapter_input_good,
    output logic main_3v3_below_2v85,
    output logic internal_3v3_rail_good,
    output logic switched_3v3_output_uv = 1'h1
);
    assign main_3v3_input_good = main_on;
    assign adapter_input_good = adp_on;
    // a removed main input decays under the threshold at once, the worst case
    assign main_3v3_below_2v85 = !main_on;
    assign internal_3v3_rail_good = main_on | adp_on;
    // disabled output is pulled down, so the supervisor sees undervoltage
    always @(posedge core_clk) switched_3v3_output_uv <= !switched_3v3_output_en;
endmodule : dpbr_supply_model

// ---- sim/dpbr_top_tb.sv ----
// self-checking bench for the power, boot and reset controller
// assumes dpbr_top, the supply model and the bound checker are compiled
`timescale 1ns/1ps
module dpbr_top_tb;
    logic core_clk = 1'h0, rst_b = 1'h0, main_on = 1'h0, adp_on = 1'h0;
    logic adapter_path_cfg_pin_ext = 1'h1, switched_out_enable_cfg = 1'h0;
    logic manual_reset_in = 1'h0, manual_reset_active_low = 1'h0, upstream_pd_attached = 1'h0;
    logic fw_force_debug = 1'h0, usb_tx_active = 1'h0, main_3v3_input_good, adapter_input_good;
    logic main_3v3_below_2v85, internal_3v3_rail_good, switched_3v3_output_uv;
    logic adapter_switch_close, use_main_supply, boot_run, app_load_req, core_enable, usb_bit_en;
    logic switched_3v3_output_en, output_pulldown_en, system_reset_out_n, upstream_route_en;
    logic upstream_dminus_pullup, debug_dminus_pullup, debug_route_en;
    int fail_count = 0, total_checks = 0, n;
    integer seed = 32'h17ab;
    always #25 core_clk = ~core_clk;
    dpbr_supply_model u_sup (.core_clk, .main_on, .adp_on, .switched_3v3_output_en,
        .main_3v3_input_good, .adapter_input_good, .main_3v3_below_2v85,
        .internal_3v3_rail_good, .switched_3v3_output_uv);
    dpbr_top u_dut (.core_clk, .rst_b, .main_3v3_input_good, .adapter_input_good,
        .main_3v3_below_2v85, .internal_3v3_rail_good, .adapter_path_cfg_pin_ext,
        .switched_out_enable_cfg, .switched_3v3_output_uv, .manual_reset_in,
        .manual_reset_active_low, .upstream_pd_attached, .fw_force_debug, .usb_tx_active,
        .adapter_switch_close, .use_main_supply, .boot_run, .app_load_req, .core_enable,
        .switched_3v3_output_en, .output_pulldown_en, .system_reset_out_n, .usb_bit_en,
        .upstream_dminus_pullup, .debug_dminus_pullup, .upstream_route_en, .debug_route_en);
    function automatic logic want_dbg();
        return fw_force_debug | !upstream_pd_attached;
    endfunction : want_dbg
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    // bounded wait; running out ends the run
    task automatic wait_v(ref logic s, input logic v, input string nm);
        repeat (100) if (s !== v) @(posedge core_clk);
        #1;
        chk(nm, v, s);
        if (s !== v) final_report();
    endtask : wait_v
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        step(3);
        chk("core_enable", 1'h0, core_enable);
        chk("system_reset_out_n", 1'h0, system_reset_out_n);
        chk("output_pulldown_en", 1'h1, output_pulldown_en);
        adp_on <= 1'h1;
        wait_v(adapter_switch_close, 1'h1, "adapter_switch_close");
        chk("app_load_req", 1'h0, app_load_req);
        chk("core_enable", 1'h1, core_enable);
        $display("test adapter boot done");
        @(posedge core_clk);
        main_on <= 1'h1;
        wait_v(use_main_supply, 1'h1, "use_main_supply");
        chk("boot_run", 1'h1, boot_run);
        switched_out_enable_cfg <= 1'h1;
        wait_v(switched_3v3_output_en, 1'h1, "switched_3v3_output_en");
        chk("output_pulldown_en", 1'h0, output_pulldown_en);
        wait_v(system_reset_out_n, 1'h1, "system_reset_out_n");
        $display("test switch-over done");
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            {manual_reset_in, manual_reset_active_low, usb_tx_active, upstream_pd_attached,
                fw_force_debug} <= 5'($random(seed));
            step(2);
            chk("system_reset_out_n", manual_reset_in == manual_reset_active_low,
                system_reset_out_n);
            chk("debug_route_en", want_dbg(), debug_route_en);
            chk("upstream_route_en", !want_dbg(), upstream_route_en);
            chk("debug_dminus_pullup", !usb_tx_active & want_dbg(), debug_dminus_pullup);
            chk("upstream_dminus_pullup", !usb_tx_active & !want_dbg(),
                upstream_dminus_pullup);
        end
        n = 0;
        repeat (26) begin
            step(1);
            n += int'(usb_bit_en === 1'h1);
        end
        chk("usb_bit_en pulses", 1'h1, n == 2);
        $display("test reset and usb done");
        adapter_path_cfg_pin_ext <= 1'h0;
        step(3);
        chk("adapter_switch_close", 1'h1, adapter_switch_close);
        main_on <= 1'h0;
        wait_v(boot_run, 1'h0, "boot_run");
        wait_v(app_load_req, 1'h1, "app_load_req");
        chk("adapter_switch_close", 1'h0, adapter_switch_close);
        chk("output_pulldown_en", 1'h1, output_pulldown_en);
        chk("system_reset_out_n", 1'h0, system_reset_out_n);
        $display("test hard reset done");
        final_report();
    end
endmodule : dpbr_top_tb
